// file: gpb_consts.vh
`ifndef GPB_CONSTS_VH
`define GPB_CONSTS_VH
// ==========================================
// Register offsets (byte addresses)
`define GPB_OFS_DATA_LO   12'h000
`define GPB_OFS_DATA_HI   12'h3FC
`define GPB_OFS_DIR       12'h400
`define GPB_OFS_IS        12'h404
`define GPB_OFS_IBE       12'h408
`define GPB_OFS_IEV       12'h40C
`define GPB_OFS_IM        12'h410
`define GPB_OFS_RIS       12'h414
`define GPB_OFS_MIS       12'h418
`define GPB_OFS_ICR       12'h41C
`define GPB_OFS_AFSEL     12'h420
`define GPB_OFS_DR2       12'h500
`define GPB_OFS_DR4       12'h504
`define GPB_OFS_DR8       12'h508
`define GPB_OFS_ODR       12'h50C
`define GPB_OFS_PUR       12'h510
`define GPB_OFS_PDR       12'h514
`define GPB_OFS_SLR       12'h518
`define GPB_OFS_DEN       12'h51C
`define GPB_OFS_LOCK      12'h520
`define GPB_OFS_CR        12'h524
`define GPB_OFS_ID_LO     12'hFD0
`define GPB_OFS_ID_HI     12'hFFC
// ==========================================
// Field positions and constants
`define GPB_MASK_LSB      2
`define GPB_OFS_SEL_MSB   11
`define GPB_UNLOCK_KEY    32'h1ACC_E551
`define GPB_ZERO8         8'h00
`define GPB_ONES8         8'hFF
`define GPB_ZERO32        32'h0000_0000
`define GPB_DR2_RESET     8'hFF
`define GPB_IRQ_PIN       3'h4
`define GPB_ID_BASE       32'h0000_0060
`endif

// file: gpb_irq_cell.v
`timescale 1ns/1ps
// ==========================================
// Per-pin interrupt detector with sticky edge flag
module gpb_irq_cell (
    // Clock and reset
    input  wire pclk,
    input  wire presetn,
    // Configuration
    input  wire sense_level,
    input  wire dual_edge,
    input  wire polarity_high,
    // Pin and clear
    input  wire pin_in,
    input  wire clear,
    // Status
    output wire raw_state
);
    reg  prev_reg;
    reg  edge_flag_reg;
    wire rise;
    wire fall;
    wire edge_hit;
    wire level_hit;

    assign rise      = pin_in & ~prev_reg;
    assign fall      = ~pin_in & prev_reg;
    assign edge_hit  = dual_edge ? (rise | fall) : (polarity_high ? rise : fall);
    assign level_hit = polarity_high ? pin_in : ~pin_in;
    // Level mode follows the pin; clear has no lasting effect there
    assign raw_state = sense_level ? level_hit : edge_flag_reg;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg      <= 1'b0;
            edge_flag_reg <= 1'b0;
        end else begin
            prev_reg <= pin_in;
            // Set wins over a simultaneous clear
            if (!sense_level && edge_hit)
                edge_flag_reg <= 1'b1;
            else if (clear || sense_level)
                edge_flag_reg <= 1'b0;
        end
    end
endmodule

// file: gpb_port.v
// What this block does
// - Direction bit 0 makes pin input sampled; 1 drives pin from data.
// - Data accesses use address bits 9:2 as per-bit mask.
// - Data register decodes as 256 consecutive word locations.
// - Write changes only bits whose mask address bit is one.
// - Read returns masked-off bits as zero.
// - Per pin rising, falling, both edges, high or low level detection.
// - All enabled pin interrupts merge into one port interrupt output.
// - Edge interrupt stays latched until software clears it.
// - Raw status shows condition met regardless of enable mask.
// - Masked status shows only enabled pending conditions.
// - Writing one to clear register clears pending; zero does nothing.
// - Enabled trigger pin event also pulses converter trigger output.
// - Ownership bit set hands pin to peripheral; else software controls.
// - Protected ownership writes need unlock key and commit permit bits.
// - Reset tri-states ordinary pins; debug pins default to peripheral.
// - Reset returns ordinary and debug pins to default configuration.
// - Pad bits select 2, 4, 8 mA drive, open-drain, pulls, input enable.
// - Slew control bit per pin, effective only with 8 mA drive.
// - Read-only identification words identify the block.
// - Each port is an identical instance of this block.
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "gpb_consts.vh"
module gpb_port #(
    parameter [7:0]  PIN_PRESENT  = 8'hFF,
    parameter [7:0]  DEBUG_PINS   = 8'h00,
    parameter [31:0] IDENT_WORD   = 32'h0000_0000,
    parameter        HAS_ADC_TRIG = 1
) (
    // APB slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Pins
    input  wire [7:0]  pin_in,
    output reg  [7:0]  pin_out,
    output reg  [7:0]  pin_oe,
    // Peripheral side
    input  wire [7:0]  periph_out,
    input  wire [7:0]  periph_oe,
    output reg  [7:0]  periph_in,
    // Pad controls
    output reg  [7:0]  pad_drive_low,
    output reg  [7:0]  pad_drive_mid,
    output reg  [7:0]  pad_drive_high,
    output reg  [7:0]  pad_slew,
    output reg  [7:0]  pad_open_drain,
    output reg  [7:0]  pad_pullup,
    output reg  [7:0]  pad_pulldown,
    output reg  [7:0]  pad_input_en,
    // Events
    output reg         port_irq,
    output reg         adc_trigger
);
    // ==========================================
    // Registers
    reg  [7:0] pin_value_reg;
    reg  [7:0] pin_direction_reg;
    reg  [7:0] irq_sense_select_reg;
    reg  [7:0] irq_dual_edge_select_reg;
    reg  [7:0] irq_polarity_select_reg;
    reg  [7:0] irq_enable_mask_reg;
    reg  [7:0] peripheral_ownership_select_reg;
    reg  [7:0] drive_low_select_reg;
    reg  [7:0] drive_mid_select_reg;
    reg  [7:0] drive_high_select_reg;
    reg  [7:0] open_drain_reg;
    reg  [7:0] weak_pullup_enable_reg;
    reg  [7:0] weak_pulldown_enable_reg;
    reg  [7:0] slew_reg;
    reg  [7:0] digital_input_enable_reg;
    reg  [7:0] commit_permit_bits_reg;
    reg        unlocked_reg;
    reg  [7:0] trig_raw_prev_reg;
    reg  [7:0] irq_clear_next;
    reg  [31:0] rdata_next;

    wire [7:0] irq_raw_state;
    wire [7:0] irq_masked_state;
    wire [7:0] mask_bits;
    wire [7:0] sw_in;
    wire [7:0] wdata8;
    wire       setup;
    wire       wr_en;
    wire       is_data;
    wire       is_ident;
    wire [7:0] afsel_wmask;
    wire [11:0] id_off;

    assign setup     = psel & ~penable;
    // Writes land with the completing access phase, never in setup
    assign wr_en     = psel & penable & pready & pwrite;
    assign mask_bits = paddr[`GPB_MASK_LSB+7:`GPB_MASK_LSB];
    // Whole 1 KB data window, 256 words
    assign is_data   = (paddr <= `GPB_OFS_DATA_HI);
    assign is_ident  = (paddr >= `GPB_OFS_ID_LO);
    // Byte offset inside the identification window; bits 5:2 give the word index
    assign id_off    = paddr - `GPB_OFS_ID_LO;
    assign wdata8    = pwdata[7:0] & PIN_PRESENT;
    // Input sampling gated by digital input enable
    assign sw_in     = pin_in & digital_input_enable_reg;
    assign irq_masked_state = irq_raw_state & irq_enable_mask_reg;
    // Unpermitted bits keep their value
    assign afsel_wmask = unlocked_reg ? commit_permit_bits_reg
                                      : commit_permit_bits_reg & ~DEBUG_PINS;

    // ==========================================
    // Per-pin interrupt detectors
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_irq
            gpb_irq_cell u_cell (
                .pclk          (pclk),
                .presetn       (presetn),
                .sense_level   (irq_sense_select_reg[gi]),
                .dual_edge     (irq_dual_edge_select_reg[gi]),
                .polarity_high (irq_polarity_select_reg[gi]),
                .pin_in        (sw_in[gi] & PIN_PRESENT[gi]),
                .clear         (irq_clear_next[gi]),
                .raw_state     (irq_raw_state[gi])
            );
        end
    endgenerate

    // ==========================================
    // Write decode
    always @* begin
        irq_clear_next = `GPB_ZERO8;
        if (wr_en && paddr == `GPB_OFS_ICR)
            irq_clear_next = wdata8;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_value_reg                   <= `GPB_ZERO8;
            pin_direction_reg               <= `GPB_ZERO8;
            irq_sense_select_reg            <= `GPB_ZERO8;
            irq_dual_edge_select_reg        <= `GPB_ZERO8;
            irq_polarity_select_reg         <= `GPB_ZERO8;
            irq_enable_mask_reg             <= `GPB_ZERO8;
            peripheral_ownership_select_reg <= DEBUG_PINS;
            drive_low_select_reg            <= `GPB_DR2_RESET;
            drive_mid_select_reg            <= `GPB_ZERO8;
            drive_high_select_reg           <= `GPB_ZERO8;
            open_drain_reg                  <= `GPB_ZERO8;
            weak_pullup_enable_reg          <= DEBUG_PINS;
            weak_pulldown_enable_reg        <= `GPB_ZERO8;
            slew_reg                        <= `GPB_ZERO8;
            digital_input_enable_reg        <= DEBUG_PINS;
            commit_permit_bits_reg          <= `GPB_ONES8 & ~DEBUG_PINS;
            unlocked_reg                    <= 1'b0;
        end else begin
            // Input pins capture the pad; output pins keep written value
            pin_value_reg <= (pin_value_reg & pin_direction_reg)
                           | (sw_in & ~pin_direction_reg & PIN_PRESENT);
            if (wr_en) begin
                if (is_data)
                    pin_value_reg <= ((pin_value_reg & pin_direction_reg)
                                    | (sw_in & ~pin_direction_reg & PIN_PRESENT)
                                    ) & ~mask_bits
                                   | (wdata8 & mask_bits);
                case (paddr)
                    `GPB_OFS_DIR: pin_direction_reg        <= wdata8;
                    `GPB_OFS_IS:  irq_sense_select_reg     <= wdata8;
                    `GPB_OFS_IBE: irq_dual_edge_select_reg <= wdata8;
                    `GPB_OFS_IEV: irq_polarity_select_reg  <= wdata8;
                    `GPB_OFS_IM:  irq_enable_mask_reg      <= wdata8;
                    `GPB_OFS_AFSEL: begin
                        peripheral_ownership_select_reg <=
                            (peripheral_ownership_select_reg & ~afsel_wmask)
                          | (wdata8 & afsel_wmask);
                    end
                    // Drive selects are mutually exclusive
                    `GPB_OFS_DR2: begin
                        drive_low_select_reg  <= wdata8;
                        drive_mid_select_reg  <= drive_mid_select_reg & ~wdata8;
                        drive_high_select_reg <= drive_high_select_reg & ~wdata8;
                    end
                    `GPB_OFS_DR4: begin
                        drive_mid_select_reg  <= wdata8;
                        drive_low_select_reg  <= drive_low_select_reg & ~wdata8;
                        drive_high_select_reg <= drive_high_select_reg & ~wdata8;
                    end
                    `GPB_OFS_DR8: begin
                        drive_high_select_reg <= wdata8;
                        drive_low_select_reg  <= drive_low_select_reg & ~wdata8;
                        drive_mid_select_reg  <= drive_mid_select_reg & ~wdata8;
                    end
                    `GPB_OFS_ODR: open_drain_reg           <= wdata8;
                    `GPB_OFS_PUR: begin
                        weak_pullup_enable_reg   <= wdata8;
                        weak_pulldown_enable_reg <= weak_pulldown_enable_reg & ~wdata8;
                    end
                    `GPB_OFS_PDR: begin
                        weak_pulldown_enable_reg <= wdata8;
                        weak_pullup_enable_reg   <= weak_pullup_enable_reg & ~wdata8;
                    end
                    `GPB_OFS_SLR: slew_reg                 <= wdata8;
                    `GPB_OFS_DEN: digital_input_enable_reg <= wdata8;
                    `GPB_OFS_LOCK: unlocked_reg <= (pwdata == `GPB_UNLOCK_KEY);
                    `GPB_OFS_CR: begin
                        if (unlocked_reg)
                            commit_permit_bits_reg <= wdata8 & DEBUG_PINS
                                                    | (commit_permit_bits_reg & ~DEBUG_PINS);
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ==========================================
    // Read decode
    always @* begin
        rdata_next = `GPB_ZERO32;
        if (is_data)
            rdata_next = {24'h00_0000, pin_value_reg & mask_bits & PIN_PRESENT};
        else if (is_ident)
            rdata_next = IDENT_WORD | `GPB_ID_BASE
                       | {24'h00_0000, 4'h0, id_off[5:2]};
        else begin
            case (paddr)
                `GPB_OFS_DIR:   rdata_next[7:0] = pin_direction_reg;
                `GPB_OFS_IS:    rdata_next[7:0] = irq_sense_select_reg;
                `GPB_OFS_IBE:   rdata_next[7:0] = irq_dual_edge_select_reg;
                `GPB_OFS_IEV:   rdata_next[7:0] = irq_polarity_select_reg;
                `GPB_OFS_IM:    rdata_next[7:0] = irq_enable_mask_reg;
                `GPB_OFS_RIS:   rdata_next[7:0] = irq_raw_state;
                `GPB_OFS_MIS:   rdata_next[7:0] = irq_masked_state;
                `GPB_OFS_AFSEL: rdata_next[7:0] = peripheral_ownership_select_reg;
                `GPB_OFS_DR2:   rdata_next[7:0] = drive_low_select_reg;
                `GPB_OFS_DR4:   rdata_next[7:0] = drive_mid_select_reg;
                `GPB_OFS_DR8:   rdata_next[7:0] = drive_high_select_reg;
                `GPB_OFS_ODR:   rdata_next[7:0] = open_drain_reg;
                `GPB_OFS_PUR:   rdata_next[7:0] = weak_pullup_enable_reg;
                `GPB_OFS_PDR:   rdata_next[7:0] = weak_pulldown_enable_reg;
                `GPB_OFS_SLR:   rdata_next[7:0] = slew_reg;
                `GPB_OFS_DEN:   rdata_next[7:0] = digital_input_enable_reg;
                `GPB_OFS_LOCK:  rdata_next[0]   = ~unlocked_reg;
                `GPB_OFS_CR:    rdata_next[7:0] = commit_permit_bits_reg;
                default:        rdata_next      = `GPB_ZERO32;
            endcase
            // Unbonded bits read as zero; the lock status bit is no pin
            if (paddr != `GPB_OFS_LOCK)
                rdata_next[7:0] = rdata_next[7:0] & PIN_PRESENT;
        end
    end

    // ==========================================
    // APB answer: one wait-free access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= `GPB_ZERO32;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= 1'b0;
            if (setup && !pwrite)
                prdata <= rdata_next;
        end
    end

    // ==========================================
    // Pins, pads and events
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out        <= `GPB_ZERO8;
            pin_oe         <= `GPB_ZERO8;
            periph_in      <= `GPB_ZERO8;
            pad_drive_low  <= `GPB_DR2_RESET;
            pad_drive_mid  <= `GPB_ZERO8;
            pad_drive_high <= `GPB_ZERO8;
            pad_slew       <= `GPB_ZERO8;
            pad_open_drain <= `GPB_ZERO8;
            pad_pullup     <= `GPB_ZERO8;
            pad_pulldown   <= `GPB_ZERO8;
            pad_input_en   <= `GPB_ZERO8;
            port_irq       <= 1'b0;
            adc_trigger    <= 1'b0;
            trig_raw_prev_reg <= `GPB_ZERO8;
        end else begin
            // Peripheral owns the pin when selected
            pin_out <= PIN_PRESENT & ((peripheral_ownership_select_reg & periph_out)
                     | (~peripheral_ownership_select_reg & pin_value_reg));
            pin_oe  <= PIN_PRESENT & ((peripheral_ownership_select_reg & periph_oe)
                     | (~peripheral_ownership_select_reg & pin_direction_reg));
            periph_in      <= sw_in & peripheral_ownership_select_reg;
            pad_drive_low  <= drive_low_select_reg;
            pad_drive_mid  <= drive_mid_select_reg;
            pad_drive_high <= drive_high_select_reg;
            pad_slew       <= slew_reg & drive_high_select_reg;
            pad_open_drain <= open_drain_reg;
            pad_pullup     <= weak_pullup_enable_reg;
            pad_pulldown   <= weak_pulldown_enable_reg;
            pad_input_en   <= digital_input_enable_reg;
            port_irq       <= |irq_masked_state;
            // Track the masked status so enabling a pending event also pulses
            trig_raw_prev_reg <= irq_masked_state;
            // One pulse per new enabled event on the trigger pin
            adc_trigger <= (HAS_ADC_TRIG != 0)
                         & irq_masked_state[`GPB_IRQ_PIN]
                         & ~trig_raw_prev_reg[`GPB_IRQ_PIN];
        end
    end
endmodule

// file: gpb_port_checker.sv
`timescale 1ns/1ps
// ==========================================
// Port-level relations of the port block
module gpb_port_checker (
    // Clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // Bus
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    // Pads
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pad_drive_low,
    input wire logic [7:0] pad_drive_mid,
    input wire logic [7:0] pad_drive_high,
    input wire logic [7:0] pad_slew,
    input wire logic [7:0] pad_pullup,
    input wire logic [7:0] pad_pulldown,
    // Events
    input wire logic       port_irq,
    input wire logic       adc_trigger
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================
    // Bus answer
    chk_ready_after_setup: assert property (psel && !penable |=> pready && penable)
        else $error("no ready in access phase");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_no_slave_err: assert property (pready |-> !pslverr)
        else $error("unexpected slave error");
    // ==========================================
    // Events
    chk_trigger_pulse: assert property (adc_trigger |=> !adc_trigger)
        else $error("trigger longer than one cycle");
    chk_trigger_with_irq: assert property (adc_trigger |-> ##[0:2] port_irq)
        else $error("trigger without port interrupt");
    // ==========================================
    // Pads
    chk_drive_exclusive: assert property (((pad_drive_low & pad_drive_mid) |
        (pad_drive_low & pad_drive_high) | (pad_drive_mid & pad_drive_high)) == 8'h00)
        else $error("two drive strengths on one pin");
    chk_pull_exclusive: assert property ((pad_pullup & pad_pulldown) == 8'h00)
        else $error("pull-up and pull-down together");
    chk_slew_needs_8ma: assert property ((pad_slew & ~pad_drive_high) == 8'h00)
        else $error("slew control without 8 mA drive");
    chk_reset_quiet: assert property (!$past(presetn) |->
        pin_oe == 8'h00 && !port_irq && pad_drive_low == 8'hFF)
        else $error("outputs not at reset state");
    cover property (adc_trigger);
    cover property ($rose(port_irq));
    cover property ($fell(port_irq));
endmodule

bind gpb_port gpb_port_checker chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .pin_oe(pin_oe),
    .pad_drive_low(pad_drive_low), .pad_drive_mid(pad_drive_mid),
    .pad_drive_high(pad_drive_high), .pad_slew(pad_slew),
    .pad_pullup(pad_pullup), .pad_pulldown(pad_pulldown),
    .port_irq(port_irq), .adc_trigger(adc_trigger)
);

// file: gpb_pin_model.sv
`timescale 1ns/1ps
// ==========================================
// Board side of the pins
module gpb_pin_model (
    // Clock
    input wire logic       pclk,
    // Port side
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pad_pullup,
    input wire logic [7:0] pad_pulldown,
    // External source
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    // Level at the pads
    output logic [7:0]     pin_lvl
);
    logic [7:0] last = 8'h00;
    // Floating net flips each cycle so a stale level never reads as valid
    always @(posedge pclk) last <= ~pin_lvl;
    // External source holds its level until told otherwise
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) |
        (~pin_oe & ~ext_en & (pad_pullup | (~pad_pulldown & last)));
endmodule

// file: tb_gpb_port.sv
`timescale 1ns/1ps
`include "gpb_consts.vh"
module tb_gpb_port;
    localparam [7:0]  PRES = 8'hDF;
    localparam [7:0]  DBG  = 8'h80;
    localparam [31:0] ZW   = 32'h0000_0000;
    localparam [31:0] FW   = 32'h0000_00FF;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [7:0]  ext_val = 8'h00;
    logic [7:0]  ext_en = 8'hFF;
    logic [7:0]  periph_out = 8'h80;
    logic [7:0]  periph_oe = 8'h80;
    logic        adc_seen = 1'b0;
    logic [31:0] rd;
    wire  [31:0] prdata;
    wire         pready, port_irq, adc_trigger;
    wire  [7:0]  pin_in, pin_out, pin_oe, pad_pullup, pad_pulldown, pad_input_en, pad_slew;
    wire  [7:0]  pad_open_drain;
    int          miscompares = 0;
    int          tests_run = 0;

    gpb_port #(.PIN_PRESENT(PRES), .DEBUG_PINS(DBG), .IDENT_WORD(ZW), .HAS_ADC_TRIG(1)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .periph_out(periph_out),
        .periph_oe(periph_oe), .periph_in(), .pad_drive_low(), .pad_drive_mid(),
        .pad_drive_high(), .pad_slew(pad_slew), .pad_open_drain(pad_open_drain),
        .pad_pullup(pad_pullup), .pad_pulldown(pad_pulldown), .pad_input_en(pad_input_en),
        .port_irq(port_irq), .adc_trigger(adc_trigger));
    gpb_pin_model pins (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pad_pullup(pad_pullup), .pad_pulldown(pad_pulldown), .ext_val(ext_val),
        .ext_en(ext_en), .pin_lvl(pin_in));

    initial begin
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) if (adc_trigger === 1'b1) adc_seen <= 1'b1;

    task automatic tally_and_finish;
        if (miscompares == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // Request held until ready is sampled high, then released
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, ZW);
        chk(rd, e);
    endtask
    task automatic do_reset;
        @(posedge pclk) presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask
    task automatic irq_case(input logic s, d, v, a, b, e);
        @(posedge pclk) ext_val[0] <= a;
        wr(`GPB_OFS_IM, ZW);
        wr(`GPB_OFS_IS, {31'h0, s});
        wr(`GPB_OFS_IBE, {31'h0, d});
        wr(`GPB_OFS_IEV, {31'h0, v});
        wr(`GPB_OFS_ICR, FW);
        wr(`GPB_OFS_IM, 32'h0000_0001);
        @(posedge pclk) ext_val[0] <= b;
        repeat (3) @(posedge pclk);
        rdc(`GPB_OFS_RIS, {31'h0, e});
        rdc(`GPB_OFS_MIS, {31'h0, e});
        chk({31'h0, port_irq}, {31'h0, e});
    endtask

    initial begin
        #300000;
        miscompares++;
        tally_and_finish;
    end
    initial begin
        do_reset;
        chk({24'h0, pad_pullup}, {24'h0, DBG});
        chk({24'h0, pad_input_en}, {24'h0, DBG});
        rdc(`GPB_OFS_AFSEL, {24'h0, DBG});
        rdc(`GPB_OFS_DIR, ZW);
        rdc(`GPB_OFS_DR2, {24'h0, PRES});
        wr(`GPB_OFS_DEN, FW);
        wr(`GPB_OFS_DIR, FW);
        rdc(`GPB_OFS_DIR, {24'h0, PRES});
        wr(12'h1FC, FW);
        wr(12'h098, 32'h0000_00EB);
        rdc(12'h1FC, 32'h0000_005B);
        rdc(12'h0C4, 32'h0000_0011);
        chk({24'h0, pin_out & 8'h5F}, 32'h0000_005B);
        wr(`GPB_OFS_DIR, ZW);
        @(posedge pclk) ext_val <= 8'hA5;
        // Every mask location returns only its own bits; pin 7 is held high
        for (int i = 0; i < 256; i++) begin
            rdc({2'b00, i[7:0], 2'b00}, {24'h0, i[7:0] & 8'h85});
        end
        irq_case(0, 0, 1, 0, 1, 1);
        irq_case(0, 0, 0, 1, 0, 1);
        irq_case(0, 0, 1, 1, 0, 0);
        irq_case(0, 1, 0, 1, 0, 1);
        irq_case(0, 1, 0, 0, 1, 1);
        irq_case(1, 0, 1, 0, 1, 1);
        irq_case(1, 0, 0, 1, 0, 1);
        wr(`GPB_OFS_IM, ZW);
        rdc(`GPB_OFS_RIS, 32'h0000_0001);
        rdc(`GPB_OFS_MIS, ZW);
        chk({31'h0, port_irq}, ZW);
        irq_case(0, 0, 1, 0, 1, 1);
        @(posedge pclk) ext_val[0] <= 1'b0;
        rdc(`GPB_OFS_RIS, 32'h0000_0001);
        wr(`GPB_OFS_ICR, 32'h0000_00FE);
        rdc(`GPB_OFS_RIS, 32'h0000_0001);
        wr(`GPB_OFS_ICR, 32'h0000_0001);
        rdc(`GPB_OFS_RIS, ZW);
        chk({31'h0, port_irq}, ZW);
        wr(`GPB_OFS_IM, ZW);
        wr(`GPB_OFS_IS, ZW);
        wr(`GPB_OFS_IEV, 32'h0000_0010);
        wr(`GPB_OFS_ICR, FW);
        @(posedge pclk) ext_val[4] <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({31'h0, adc_seen}, ZW);
        wr(`GPB_OFS_IM, 32'h0000_0010);
        repeat (3) @(posedge pclk);
        chk({31'h0, adc_seen}, 32'h0000_0001);
        chk({31'h0, port_irq}, 32'h0000_0001);
        wr(`GPB_OFS_AFSEL, ZW);
        rdc(`GPB_OFS_AFSEL, {24'h0, DBG});
        wr(`GPB_OFS_CR, FW);
        rdc(`GPB_OFS_CR, 32'h0000_005F);
        wr(`GPB_OFS_LOCK, `GPB_UNLOCK_KEY);
        rdc(`GPB_OFS_LOCK, ZW);
        wr(`GPB_OFS_CR, FW);
        rdc(`GPB_OFS_CR, {24'h0, PRES});
        wr(`GPB_OFS_AFSEL, ZW);
        rdc(`GPB_OFS_AFSEL, ZW);
        wr(`GPB_OFS_DR8, 32'h0000_0001);
        rdc(`GPB_OFS_DR2, 32'h0000_00DE);
        wr(`GPB_OFS_SLR, 32'h0000_0003);
        wr(`GPB_OFS_ODR, FW);
        repeat (2) @(posedge pclk);
        chk({24'h0, pad_slew & 8'h03}, 32'h0000_0001);
        chk({24'h0, pad_open_drain}, {24'h0, PRES});
        rdc(`GPB_OFS_ID_LO, 32'h0000_0060);
        wr(`GPB_OFS_ID_LO, 32'hFFFF_FFFF);
        rdc(`GPB_OFS_ID_LO, 32'h0000_0060);
        rdc(12'hFE0, 32'h0000_0064);
        wr(12'h600, FW);
        rdc(12'h600, ZW);
        do_reset;
        rdc(`GPB_OFS_AFSEL, {24'h0, DBG});
        rdc(`GPB_OFS_LOCK, 32'h0000_0001);
        chk({24'h0, pad_pullup}, {24'h0, DBG});
        tally_and_finish;
    end
endmodule
